// [logic/uog_global.sv]
`timescale 1ns/1ps
module uog_global
  import uog_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Transceiver side pins, asynchronous
  input wire uog_pin_t pin_i,
  // Core side status, same clock
  input wire logic [31:0] core_irq_i,
  input wire logic bus_master_idle_i,
  // Control outputs
  output uog_ctrl_t ctrl_o,
  output logic core_soft_reset_o,
  output logic bus_domain_soft_reset_o,
  output logic frame_counter_reset_o,
  output logic rx_fifo_flush_o,
  output logic tx_fifo_flush_o,
  output logic [4:0] tx_fifo_select_o,
  output logic irq_o
);

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  uog_pin_t meta_r;
  uog_pin_t sync_r;
  uog_pin_t prev_r;

  // Two flops, then a history stage for edge detection
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
    end else begin
      meta_r <= pin_i;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Wishbone decode

  logic ack_r;
  logic [31:0] rdat_r;
  logic [31:0] ctrl_r;
  logic [31:0] ev_r;
  logic [31:0] bcfg_r;
  logic [31:0] lcfg_r;
  logic neg_ok_r;
  logic core_rst_r;
  logic bus_rst_r;
  logic frm_rst_r;
  logic rx_fl_r;
  logic tx_fl_r;
  logic [4:0] tx_sel_r;
  logic [3:0] rst_cnt_r;
  logic [3:0] rx_cnt_r;
  logic [3:0] tx_cnt_r;

  wire req = wb_cyc_i & wb_stb_i;
  // Write takes effect on the edge where ack is sampled
  wire wr = req & wb_we_i & ack_r;
  wire [31:0] lane = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                      {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire [31:0] wset = wb_dat_i & lane;
  wire [31:0] wclr = ~wb_dat_i & lane;
  wire hit_cs = wb_adr_i == OFS_CTRL_STS;
  wire hit_ev = wb_adr_i == OFS_EVENTS;
  wire hit_bc = wb_adr_i == OFS_BUS_CFG;
  wire hit_lc = wb_adr_i == OFS_LINK_CFG;
  wire hit_rc = wb_adr_i == OFS_RST_CTRL;
  wire hit_ci = wb_adr_i == OFS_CORE_IRQ;
  wire wr_cs = wr & hit_cs;
  wire wr_ev = wr & hit_ev;
  wire wr_bc = wr & hit_bc;
  wire wr_lc = wr & hit_lc;
  wire wr_rc = wr & hit_rc;

  //////////////////////////////////////////////////////////////////////////
  // Read-back values

  wire [31:0] cs_view = (ctrl_r & WM_CTRL_STS)
    | (32'(sync_r.session_request_ok) << B_SESSION_REQUEST_OK) // [RQ1]
    | (32'(neg_ok_r) << B_NEG_OK) // [RQ3]
    | (32'(sync_r.id_b_device) << B_ID) // [RQ6]
    | (32'(sync_r.short_debounce) << B_DEB_LEN) // [RQ7]
    | (32'(sync_r.a_valid) << B_A_VALID) // [RQ8]
    | (32'(sync_r.b_valid) << B_B_VALID); // [RQ8]
  wire [31:0] rc_view = RST_RST_CTRL
    | (32'(core_rst_r) << B_CORE_RST)
    | (32'(bus_rst_r) << B_BUS_RST)
    | (32'(frm_rst_r) << B_FRM_RST)
    | (32'(rx_fl_r) << B_RX_FLUSH)
    | (32'(tx_fl_r) << B_TX_FLUSH)
    | {21'h00_0000, tx_sel_r, 6'h00}
    | (32'(bus_master_idle_i) << B_MST_IDLE);
  // Core status with the OTG summary bit folded in
  wire [31:0] ci_view = core_irq_i
    | (32'(|ev_r) << B_CORE_OTG);
  wire [31:0] rd_mux = hit_cs ? cs_view
    : hit_ev ? ev_r
    : hit_bc ? bcfg_r
    : hit_lc ? lcfg_r
    : hit_rc ? rc_view
    : hit_ci ? ci_view
    : 32'h0000_0000;

  // One wait state; unmapped addresses answer with zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end else begin
      ack_r <= req & ~ack_r & ~core_rst_r; // [RQ19]
      rdat_r <= rd_mux;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Event detection

  wire sok_chg = sync_r.session_request_ok ^ prev_r.session_request_ok; // [RQ10]
  wire neg_clear = wr_cs & wb_sel_i[1] & wb_dat_i[B_NEG_REQ]; // [RQ3]
  wire neg_ok_nxt = neg_clear ? 1'b0
    : (sync_r.neg_ok & ~prev_r.neg_ok) ? 1'b1
    : (~sync_r.neg_ok & prev_r.neg_ok) ? 1'b0
    : neg_ok_r;
  wire nok_chg = neg_ok_nxt ^ neg_ok_r; // [RQ10]
  wire host_mode_nxt = lcfg_r[B_F_HOST]
    | (~lcfg_r[B_F_DEV] & sync_r.host_detect); // [RQ18]
  wire deb_ok = host_mode_nxt & lcfg_r[B_SRP_EN]
    & lcfg_r[B_HNP_EN]; // [RQ12]
  wire [31:0] ev_set = 
      (32'(sync_r.vbus_low & ~prev_r.vbus_low) << B_SESS_END) // [RQ9]
    | (32'(sok_chg) << B_SOK_CHG)
    | (32'(nok_chg) << B_NOK_CHG)
    | (32'(sync_r.neg_seen & ~prev_r.neg_seen) << B_NEG_DET) // [RQ11]
    | (32'(sync_r.a_timeout & ~prev_r.a_timeout) << B_A_TOUT) // [RQ11]
    | (32'(deb_ok & sync_r.debounced & ~prev_r.debounced)
       << B_DEB_DONE);
  // Write-one-to-clear; a set in the same cycle wins
  wire [31:0] ev_w1c = wr_ev ? (wset & WM_EVENTS) : 32'h0000_0000;
  wire [31:0] ev_nxt = (ev_r & ~ev_w1c) | ev_set; // [RQ23]
  // Falling change flag releases both request bits
  wire nok_fall = ev_r[B_NOK_CHG] & ~ev_nxt[B_NOK_CHG];

  // Event flags and negotiation result
  always_ff @(posedge clk_i) begin
    if (rst_i | core_rst_r) begin // [RQ19]
      ev_r <= 32'h0000_0000;
      neg_ok_r <= 1'b0;
    end else begin
      ev_r <= ev_nxt; // [RQ9] [RQ10] [RQ11] [RQ12]
      neg_ok_r <= neg_ok_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Control-status register

  // Zero writes to request bits count only while the change flag is set
  wire [31:0] cs_clr_ok = ev_r[B_NOK_CHG] ? WM_CTRL_STS
    : (WM_CTRL_STS & ~((32'h1 << B_SESSION_REQUEST) | (32'h1 << B_NEG_REQ)));
  wire [31:0] cs_wr = (ctrl_r | (wset & WM_CTRL_STS))
    & ~(wclr & cs_clr_ok); // [RQ2] [RQ4] [RQ5]
  wire [31:0] cs_auto = nok_fall
    ? ~((32'h1 << B_SESSION_REQUEST) | (32'h1 << B_NEG_REQ))
    : 32'hFFFF_FFFF; // [RQ2] [RQ4]
  wire [31:0] cs_nxt = (wr_cs ? cs_wr : ctrl_r) & cs_auto;

  always_ff @(posedge clk_i) begin
    if (rst_i | core_rst_r) begin // [RQ19]
      ctrl_r <= RST_CTRL_STS;
    end else begin
      ctrl_r <= cs_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Configuration registers, kept through core soft reset

  wire [31:0] bc_nxt = (bcfg_r & ~(lane & WM_BUS_CFG))
    | (wset & WM_BUS_CFG); // [RQ13] [RQ14]
  wire [31:0] lc_nxt = (lcfg_r & ~(lane & WM_LINK_CFG))
    | (wset & WM_LINK_CFG); // [RQ15] [RQ16] [RQ17] [RQ18]

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bcfg_r <= 32'h0000_0000;
      lcfg_r <= RST_LINK_CFG;
    end else begin
      bcfg_r <= wr_bc ? bc_nxt : bcfg_r;
      lcfg_r <= wr_lc ? lc_nxt : lcfg_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Soft resets and flushes

  wire set_core = wr_rc & wset[B_CORE_RST];
  wire set_bus = wr_rc & wset[B_BUS_RST];
  wire set_frm = wr_rc & wset[B_FRM_RST] & host_mode_nxt; // [RQ20]
  wire set_rx = wr_rc & wset[B_RX_FLUSH]; // [RQ21]
  wire set_tx = wr_rc & wset[B_TX_FLUSH]; // [RQ22]
  // Select field may change only while no transmit flush runs
  wire sel_wr = wr_rc & ~tx_fl_r & wb_sel_i[0] & wb_sel_i[1]; // [RQ22]
  wire rst_done = rst_cnt_r == SOFT_RST_CYCLES;
  wire rx_done = rx_cnt_r == FLUSH_CYCLES;
  wire tx_done = tx_cnt_r == FLUSH_CYCLES;

  // Core and bus soft resets self-clear after a fixed count; frame reset lasts one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      core_rst_r <= 1'b0;
      bus_rst_r <= 1'b0;
      frm_rst_r <= 1'b0;
      rst_cnt_r <= 4'h0;
    end else begin
      core_rst_r <= set_core | (core_rst_r & ~rst_done); // [RQ19]
      bus_rst_r <= set_bus | (bus_rst_r & ~rst_done); // [RQ20]
      frm_rst_r <= set_frm; // [RQ20]
      rst_cnt_r <= (core_rst_r | bus_rst_r) & ~rst_done
        ? rst_cnt_r + 4'h1 : 4'h0;
    end
  end

  // Flush bits stay set until the flush has run its course
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_fl_r <= 1'b0;
      tx_fl_r <= 1'b0;
      rx_cnt_r <= 4'h0;
      tx_cnt_r <= 4'h0;
      tx_sel_r <= 5'h00;
    end else begin
      rx_fl_r <= set_rx | core_rst_r | (rx_fl_r & ~rx_done); // [RQ21]
      tx_fl_r <= set_tx | core_rst_r | (tx_fl_r & ~tx_done); // [RQ22]
      rx_cnt_r <= rx_fl_r & ~rx_done ? rx_cnt_r + 4'h1 : 4'h0;
      tx_cnt_r <= tx_fl_r & ~tx_done ? tx_cnt_r + 4'h1 : 4'h0;
      tx_sel_r <= sel_wr ? wb_dat_i[10:6] : tx_sel_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Registered outputs

  uog_ctrl_t ctrl_nxt;
  always_comb begin
    ctrl_nxt = '0;
    ctrl_nxt.session_request = cs_nxt[B_SESSION_REQUEST];
    ctrl_nxt.vbus_request = cs_nxt[B_SESSION_REQUEST] & lcfg_r[B_SRP_EN]; // [RQ16]
    ctrl_nxt.negotiation_request = cs_nxt[B_NEG_REQ]; // [RQ4]
    ctrl_nxt.host_neg_en = cs_nxt[B_HNEG_EN] & host_mode_nxt; // [RQ5]
    ctrl_nxt.dev_neg_en = cs_nxt[B_DNEG_EN] & ~host_mode_nxt; // [RQ5]
    ctrl_nxt.srp_en = lcfg_r[B_SRP_EN]; // [RQ16]
    ctrl_nxt.hnp_en = lcfg_r[B_HNP_EN]; // [RQ16]
    ctrl_nxt.timeout_cal = lcfg_r[2:0]; // [RQ15]
    ctrl_nxt.turnaround_time = lcfg_r[13:10]; // [RQ17]
    ctrl_nxt.host_mode = host_mode_nxt; // [RQ18]
    ctrl_nxt.tx_empty_level = bcfg_r[B_TX_LVL]; // [RQ14]
    ctrl_nxt.ptx_empty_level = bcfg_r[B_PTX_LVL]; // [RQ14]
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_o <= '0;
      irq_o <= 1'b0;
    end else begin
      ctrl_o <= core_rst_r ? '0 : ctrl_nxt; // [RQ19]
      irq_o <= bcfg_r[B_IRQ_GATE] & (|ci_view); // [RQ13]
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;
  assign core_soft_reset_o = core_rst_r;
  assign bus_domain_soft_reset_o = bus_rst_r;
  assign frame_counter_reset_o = frm_rst_r;
  assign rx_fifo_flush_o = rx_fl_r;
  assign tx_fifo_flush_o = tx_fl_r;
  assign tx_fifo_select_o = tx_sel_r;

endmodule : uog_global

// [logic/uog_pkg.sv]
// Overview of operation
// [RQ1] Bit 0 of control-status reports last session request result, read-only.
// [RQ2] Session request bit 1; write 0 clears only while change flag set.
// [RQ3] Negotiation result bit 8, read-only, cleared when request bit set.
// [RQ4] Bit 9 sends negotiation request; cleared like session request bit.
// [RQ5] Bit 10 host-side and bit 11 device-side negotiation enables.
// [RQ6] Bit 16 shows connector identity: 0 A-device, 1 B-device.
// [RQ7] Bit 17 shows debounce length used: 0 long, 1 short.
// [RQ8] Bits 18 and 19 show A and B session valid.
// [RQ9] Event bit 2 sets when supply drops below 0.8V; write 1 clears.
// [RQ10] Event bits 8 and 9 set on success status changes; write 1 clears.
// [RQ11] Event bit 17 on negotiation request, bit 18 on A-side timeout.
// [RQ12] Event bit 19 on debounce done, host mode, both protocols enabled.
// [RQ13] Config bit 0 gates the interrupt output; reset value masks it.
// [RQ14] Config bits 7 and 8 select half or full empty FIFO levels.
// [RQ15] Link config bits 2:0 add delay to timeout calibration.
// [RQ16] Bits 8 and 9 enable session and negotiation protocols.
// [RQ17] Field 13:10 holds turnaround time in 48MHz clocks.
// [RQ18] Bit 29 forces host, bit 30 forces device, else follow detection.
// [RQ19] Core soft reset clears control-status, flags, flushes both FIFOs.
// [RQ20] Bit 1 resets bus-domain logic; bit 2 resets host frame counter.
// [RQ21] Bit 4 flushes receive FIFO, self-clears after flush completes.
// [RQ22] Bit 5 flushes FIFO chosen by 10:6; field locked during flush.
// [RQ23] An event arriving with its clear keeps the flag set.
package uog_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL_STS = 8'h00;
  localparam logic [7:0] OFS_EVENTS = 8'h04;
  localparam logic [7:0] OFS_BUS_CFG = 8'h08;
  localparam logic [7:0] OFS_LINK_CFG = 8'h0C;
  localparam logic [7:0] OFS_RST_CTRL = 8'h10;
  localparam logic [7:0] OFS_CORE_IRQ = 8'h14;
  // Reset values
  localparam logic [31:0] RST_CTRL_STS = 32'h0000_0800;
  localparam logic [31:0] RST_LINK_CFG = 32'h0000_0A00;
  localparam logic [31:0] RST_RST_CTRL = 32'h2000_0000;
  localparam logic [31:0] RST_CORE_IRQ = 32'h0400_0020;
  // Writable bits of the control-status, event, bus and link configuration registers
  localparam logic [31:0] WM_CTRL_STS = 32'h0000_0E02;
  localparam logic [31:0] WM_EVENTS = 32'h000F_0304;
  localparam logic [31:0] WM_BUS_CFG = 32'h0000_0181;
  localparam logic [31:0] WM_LINK_CFG = 32'h6000_3F07;
  // Field positions
  localparam int B_SESSION_REQUEST_OK = 0;
  localparam int B_SESSION_REQUEST = 1;
  localparam int B_NEG_OK = 8;
  localparam int B_NEG_REQ = 9;
  localparam int B_HNEG_EN = 10;
  localparam int B_DNEG_EN = 11;
  localparam int B_ID = 16;
  localparam int B_DEB_LEN = 17;
  localparam int B_A_VALID = 18;
  localparam int B_B_VALID = 19;
  localparam int B_SESS_END = 2;
  localparam int B_SOK_CHG = 8;
  localparam int B_NOK_CHG = 9;
  localparam int B_NEG_DET = 17;
  localparam int B_A_TOUT = 18;
  localparam int B_DEB_DONE = 19;
  localparam int B_IRQ_GATE = 0;
  localparam int B_TX_LVL = 7;
  localparam int B_PTX_LVL = 8;
  localparam int B_SRP_EN = 8;
  localparam int B_HNP_EN = 9;
  localparam int B_F_HOST = 29;
  localparam int B_F_DEV = 30;
  localparam int B_CORE_RST = 0;
  localparam int B_BUS_RST = 1;
  localparam int B_FRM_RST = 2;
  localparam int B_RX_FLUSH = 4;
  localparam int B_TX_FLUSH = 5;
  localparam int B_MST_IDLE = 31;
  localparam int B_CORE_OTG = 2;
  // Timing counts in clk_i cycles
  localparam logic [3:0] FLUSH_CYCLES = 4'h8;
  localparam logic [3:0] SOFT_RST_CYCLES = 4'h8;

  // Transceiver side levels, synchronised as one group
  typedef struct packed {
    logic id_b_device;
    logic a_valid;
    logic b_valid;
    logic vbus_low;
    logic session_request_ok;
    logic neg_ok;
    logic neg_seen;
    logic a_timeout;
    logic debounced;
    logic short_debounce;
    logic host_detect;
  } uog_pin_t;

  // Control levels handed to the rest of the core
  typedef struct packed {
    logic session_request;
    logic vbus_request;
    logic negotiation_request;
    logic host_neg_en;
    logic dev_neg_en;
    logic srp_en;
    logic hnp_en;
    logic [2:0] timeout_cal;
    logic [3:0] turnaround_time;
    logic host_mode;
    logic tx_empty_level;
    logic ptx_empty_level;
  } uog_ctrl_t;
endpackage : uog_pkg

// [test/tb_top.sv]
`timescale 1ns/1ps
////////////////////////////////////////
module tb_top;
  import uog_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0000_0000;
  logic [3:0] sel = 4'hf;
  logic [3:0] lanes = 4'hf;
  logic [31:0] cirq = 32'h0000_0000;
  logic [31:0] q;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, fc_rst, rx_fl, tx_fl, irq_o, csr, bsr;
  logic [4:0] tsel;
  logic [4:0] s;
  uog_ctrl_t ctrl;
  uog_pin_t pins;
  int n_errors = 0;
  int checks = 0;
  bit seen;
  logic [7:0] ra [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18};
  logic [31:0] re [7] = '{32'h0000_0800, 32'h0, 32'h0, 32'h0000_0a00,
    32'ha000_0000, 32'h0, 32'h0};
  // Clock and devices
  always #25 clk_i = ~clk_i;
  uog_global i_uog_global (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pin_i(pins),
    .core_irq_i(cirq), .bus_master_idle_i(1'b1), .ctrl_o(ctrl),
    .core_soft_reset_o(csr), .bus_domain_soft_reset_o(bsr),
    .frame_counter_reset_o(fc_rst), .rx_fifo_flush_o(rx_fl),
    .tx_fifo_flush_o(tx_fl), .tx_fifo_select_o(tsel), .irq_o(irq_o));
  uog_phy_model i_uog_phy_model (.clk_i(clk_i), .ctrl_i(ctrl), .pin_o(pins));
  ////////////////////////////////////////
  // Compare and count
  task chk(input string nm, input logic [31:0] got, input logic [31:0] e);
    checks++;
    if (got !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, got);
    end
  endtask : chk
  // Classic cycle held until ack is sampled
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= lanes;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    wb(1'b0, a, 32'h0000_0000);
    chk($sformatf("reg %h", a), q & m, e);
  endtask : rd
  task pin(input logic [10:0] m, input logic [10:0] v);
    i_uog_phy_model.drive(m, v);
    repeat (6) @(posedge clk_i);
  endtask : pin
  task end_sim;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_sim
  // Watchdog
  initial begin
    repeat (5000) @(posedge clk_i);
    n_errors++;
    end_sim;
  end
  ////////////////////////////////////////
  // Test sequence
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 7; i++) rd(ra[i], 32'hffff_ffff, re[i]);
    $display("test reset done");
    wr(8'h08, 32'hffff_ffff);
    rd(8'h08, 32'hffff_ffff, 32'h0000_0181);
    wr(8'h0c, 32'h0000_3fff);
    rd(8'h0c, 32'hffff_ffff, 32'h0000_3f07);
    repeat (2) @(posedge clk_i);
    chk("turnaround_time", 32'(ctrl.turnaround_time), 32'h0000_000f);
    chk("lvl", 32'({ctrl.tx_empty_level, ctrl.ptx_empty_level,
      ctrl.timeout_cal}), 32'h0000_001f);
    cirq <= 32'h0000_0001;
    repeat (3) @(posedge clk_i);
    chk("irq on", 32'(irq_o), 32'h0000_0001);
    wr(8'h08, 32'h0000_0000);
    repeat (3) @(posedge clk_i);
    chk("irq off", 32'(irq_o), 32'h0000_0000);
    cirq <= 32'h0000_0000;
    $display("test config done");
    // Status pins and event flags
    pin(11'h79a, 11'h79a);
    rd(8'h00, 32'h000f_0000, 32'h000f_0000);
    rd(8'h04, 32'hffff_ffff, 32'h0006_0004);
    rd(8'h14, 32'hffff_ffff, 32'h0000_0004);
    wr(8'h04, 32'h0006_0004);
    rd(8'h04, 32'hffff_ffff, 32'h0000_0000);
    pin(11'h79a, 11'h000);
    $display("test events done");
    // Session and negotiation in device mode
    wr(8'h0c, 32'h4000_0000);
    wr(8'h00, 32'h0000_0002);
    repeat (8) @(posedge clk_i);
    chk("vbus", 32'({ctrl.session_request, ctrl.vbus_request}),
      32'h0000_0002);
    chk("dev mode", 32'(ctrl.host_mode), 32'h0000_0000);
    rd(8'h00, 32'h0000_0003, 32'h0000_0002);
    wr(8'h0c, 32'h4000_0100);
    repeat (10) @(posedge clk_i);
    rd(8'h00, 32'h0000_0003, 32'h0000_0003);
    rd(8'h04, 32'hffff_ffff, 32'h0000_0100);
    wr(8'h00, 32'h0000_0000);
    rd(8'h00, 32'h0000_0002, 32'h0000_0002);
    i_uog_phy_model.resp_dly = 20;
    wr(8'h00, 32'h0000_0202);
    repeat (30) @(posedge clk_i);
    chk("neg req", 32'(ctrl.negotiation_request), 32'h0000_0001);
    rd(8'h00, 32'h0000_0303, 32'h0000_0303);
    rd(8'h04, 32'h0000_0300, 32'h0000_0300);
    wr(8'h04, 32'h0000_0300);
    rd(8'h00, 32'h0000_0202, 32'h0000_0000);
    wr(8'h00, 32'h0000_0200);
    rd(8'h00, 32'h0000_0300, 32'h0000_0200);
    wr(8'h00, 32'h0000_0000);
    rd(8'h00, 32'h0000_0200, 32'h0000_0000);
    $display("test session done");
    // Transmit flush per select code, then receive flush
    for (int i = 0; i < 3; i++) begin
      s = (i == 2) ? 5'h10 : 5'(i);
      wr(8'h10, {21'h0, s, 6'h20});
      wr(8'h10, {21'h0, 5'h0f, 6'h00});
      chk("tx flush", 32'(tx_fl), 32'h0000_0001);
      chk("sel", 32'(tsel), 32'(s));
      repeat (10) @(posedge clk_i);
      rd(8'h10, 32'h0000_07f0, {21'h0, s, 6'h00});
    end
    wr(8'h10, 32'h0000_0010);
    repeat (2) @(posedge clk_i);
    chk("rx flush", 32'(rx_fl), 32'h0000_0001);
    repeat (10) @(posedge clk_i);
    rd(8'h10, 32'h0000_0010, 32'h0000_0000);
    $display("test flush done");
    // Frame counter reset in host mode, then core soft reset
    // Frame reset refused in device mode, one pulse in host mode
    for (int k = 0; k < 2; k++) begin
      wr(8'h0c, (k == 1) ? 32'h2000_0000 : 32'h4000_0000);
      wr(8'h10, 32'h0000_0004);
      seen = 1'b0;
      repeat (4) begin
        @(posedge clk_i);
        if (fc_rst === 1'b1) seen = 1'b1;
      end
      chk("frame", 32'(seen), 32'(k));
    end
    wr(8'h10, 32'h0000_0002);
    @(posedge clk_i);
    chk("bus rst", 32'(bsr), 32'h0000_0001);
    repeat (10) @(posedge clk_i);
    rd(8'h10, 32'h0000_0002, 32'h0000_0000);
    pin(11'h0e0, 11'h080);
    pin(11'h080, 11'h000);
    wr(8'h00, 32'h0000_0400);
    repeat (2) @(posedge clk_i);
    chk("mode", 32'({ctrl.host_mode, ctrl.host_neg_en, ctrl.dev_neg_en}),
      32'h0000_0006);
    wr(8'h10, 32'h0000_0001);
    repeat (12) @(posedge clk_i);
    rd(8'h00, 32'h0000_0602, 32'h0000_0000);
    rd(8'h04, 32'hffff_ffff, 32'h0000_0000);
    rd(8'h0c, 32'hffff_ffff, 32'h2000_0000);
    // Select field needs both low byte lanes
    lanes = 4'h1;
    wr(8'h10, 32'h0000_07c0);
    lanes = 4'hf;
    rd(8'h10, 32'h0000_07c0, 32'h0000_0000);
    $display("test soft reset done");
    wr(8'h0c, 32'h2000_0300);
    pin(11'h004, 11'h004);
    chk("enables", 32'({ctrl.srp_en, ctrl.hnp_en}), 32'h0000_0003);
    rd(8'h04, 32'hffff_ffff, 32'h0008_0000);
    $display("test debounce done");
    end_sim;
  end
endmodule : tb_top
bind uog_global uog_global_props i_uog_global_props (.clk_i, .rst_i,
  .wb_cyc_i, .wb_stb_i, .wb_ack_o, .ctrl_o, .core_soft_reset_o,
  .frame_counter_reset_o, .rx_fifo_flush_o, .tx_fifo_flush_o,
  .tx_fifo_select_o, .irq_o);

// [test/uog_global_props.sv]
`timescale 1ns/1ps
////////////////////////////////////////
// Checker on the global control ports
module uog_global_props
  import uog_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus handshake
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // Control outputs
  input wire uog_ctrl_t ctrl_o,
  input wire logic core_soft_reset_o,
  input wire logic frame_counter_reset_o,
  input wire logic rx_fifo_flush_o,
  input wire logic tx_fifo_flush_o,
  input wire logic [4:0] tx_fifo_select_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////
  // Bus answer, reset state and supply request
  property p_ack;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !core_soft_reset_o |=> wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("request not answered");
  property p_irq_rst;
    $fell(rst_i) |-> !irq_o;
  endproperty
  a_irq_rst:
    assert property (p_irq_rst) else $error("interrupt open at reset");
  property p_vbus;
    ctrl_o.vbus_request |-> ctrl_o.session_request && ctrl_o.srp_en;
  endproperty
  a_vbus:
    assert property (p_vbus) else $error("supply asked without enable");
  ////////////////////////////////////////
  // Reset and flush strobes
  property p_frm;
    frame_counter_reset_o |=> !frame_counter_reset_o;
  endproperty
  a_frm:
    assert property (p_frm) else $error("frame reset not a pulse");
  property p_rx;
    disable iff (rst_i || core_soft_reset_o)
    $rose(rx_fifo_flush_o) |=> rx_fifo_flush_o [*8] ##1 !rx_fifo_flush_o;
  endproperty
  a_rx:
    assert property (p_rx) else $error("receive flush length wrong");
  property p_sel;
    tx_fifo_flush_o && $past(tx_fifo_flush_o) |-> $stable(tx_fifo_select_o);
  endproperty
  a_sel:
    assert property (p_sel) else $error("select moved during flush");
  property p_csr;
    $rose(core_soft_reset_o) |=> core_soft_reset_o [*8] ##1 !core_soft_reset_o;
  endproperty
  a_csr:
    assert property (p_csr) else $error("soft reset length wrong");
  property p_csr_fl;
    $rose(core_soft_reset_o) |-> ##[0:2] (rx_fifo_flush_o && tx_fifo_flush_o);
  endproperty
  a_csr_fl:
    assert property (p_csr_fl) else $error("soft reset did not flush");
  property p_csr_ack;
    core_soft_reset_o && $past(core_soft_reset_o) |-> !wb_ack_o;
  endproperty
  a_csr_ack:
    assert property (p_csr_ack) else $error("answer during soft reset");
  // Main scenarios reached
  c_tx: cover property ($rose(tx_fifo_flush_o));
  c_csr: cover property ($rose(core_soft_reset_o));
  c_vbus: cover property (ctrl_o.vbus_request);
endmodule : uog_global_props

// [test/uog_phy_model.sv]
`timescale 1ns/1ps
////////////////////////////////////////
// Cable side seen through the transceiver
module uog_phy_model
  import uog_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Core control levels
  input wire uog_ctrl_t ctrl_i,
  // Transceiver levels
  output uog_pin_t pin_o
);
  int resp_dly = 2;
  int n_s = 0;
  int n_n = 0;
  initial pin_o <= '0;
  // Bench sets levels under a mask
  task drive(input uog_pin_t m, input uog_pin_t v);
    @(posedge clk_i);
    pin_o <= (pin_o & ~m) | (v & m);
  endtask : drive
  // Grant session or negotiation after resp_dly cycles
  always @(posedge clk_i) begin
    n_s <= ctrl_i.vbus_request ? n_s + 1 : 0;
    n_n <= ctrl_i.negotiation_request ? n_n + 1 : 0;
    if (n_s == resp_dly) pin_o.session_request_ok <= 1'b1;
    if (n_n == resp_dly) pin_o.neg_ok <= 1'b1;
  end
endmodule : uog_phy_model
